// ### rtl/line_exposure_regs.vh
`ifndef LINE_EXPOSURE_REGS_VH
`define LINE_EXPOSURE_REGS_VH

// clock and microsecond tick
`define CLK_FREQ_MHZ 50
`define TICK_CYCLES (`CLK_FREQ_MHZ)

// exposure method encodings
`define METHOD_TIMED 1'b0
`define METHOD_PULSE 1'b1

// trigger origin encodings
`define ORIGIN_INTERNAL 2'h0
`define ORIGIN_LINE1 2'h1
`define ORIGIN_LINE2 2'h2
`define ORIGIN_SOFTWARE 2'h3

// trigger activation encodings
`define ACT_RISING 2'h0
`define ACT_ANY 2'h1
`define ACT_HIGH 2'h2
`define ACT_LOW 2'h3

// conversion gain settings
`define GAIN_SEL_MIN 3'h1
`define GAIN_SEL_MAX 3'h4
`define GAIN_SEL_RESET 3'h4

// pixel and gain format, minimum exposure
`define PIXEL_BITS 12
`define PIXEL_MAX 12'hfff
`define MULT_FRAC_BITS 8
`define MIN_EXPOSURE_US 16'h0004

`endif

// ### rtl/line_exposure_gain_control.v
`timescale 1ns/10ps
`default_nettype none
`include "line_exposure_regs.vh"

module line_exposure_gain_control #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter TIME_BITS = 16,
    parameter OFFSET_BITS = 10,
    parameter MULT_BITS = 12,
    parameter BASELINE = 12'h040
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // exposure configuration
    input wire exposure_method_select,
    input wire [1:0] trigger_origin_select,
    input wire [1:0] triggerActivation,
    input wire triggerEnable,
    input wire [TIME_BITS-1:0] integration_duration_setting,
    input wire [TIME_BITS-1:0] post_trigger_delay,
    input wire [TIME_BITS-1:0] linePeriodSetting,
    input wire softwareTrigger,
    // external trigger lines
    input wire triggerLine1,
    input wire triggerLine2,
    // gain and offset configuration
    input wire [2:0] conversion_gain_select,
    input wire conversionGainWrite,
    input wire [MULT_BITS-1:0] post_sensor_multiplier,
    input wire signed [OFFSET_BITS-1:0] dark_offset,
    // sensor pixel stream
    input wire [`PIXEL_BITS-1:0] sensorPixel,
    input wire sensorPixelValid,
    input wire sensorLineLast,
    // sensor control
    output reg integrating,
    output reg line_begin_trigger,
    output reg integration_begin_event,
    output reg lineReadout,
    output reg [2:0] conversionGain,
    // status
    output reg triggerIgnored,
    // processed pixel stream
    output reg [`PIXEL_BITS-1:0] pixelOut,
    output reg pixelOutValid,
    output reg pixelOutLast
);

    localparam ST_IDLE = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_EXPOSE = 2'h2;
    localparam ST_READ = 2'h3;
    // divider wrap point; the divider is 8 bits, so a tick is at most 256 cycles
    localparam integer TICK_LAST = TICK_CYCLES - 1;

    reg prevLevel;
    wire [1:0] linePins;
    wire [1:0] lineSynced;
    reg [7:0] tickCount;
    reg usTick;
    reg [TIME_BITS-1:0] periodCount;
    reg [TIME_BITS-1:0] timeCount;
    reg [1:0] state;
    wire selLevel;
    wire isExternal;
    wire activeLevel;
    wire extTrigger;
    wire internalTrigger;
    wire lineTrigger;
    wire [TIME_BITS-1:0] effExposure;
    wire [TIME_BITS:0] minPeriod;
    wire [TIME_BITS:0] effPeriod;

    // external lines pass two flops; only the second stage is read
    assign linePins = {triggerLine2, triggerLine1};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg [1:0] stages;
            always @(posedge clk) begin
                if (!rst_n) begin
                    stages <= 2'h0;
                end else begin
                    stages <= {stages[0], linePins[gi]};
                end
            end
            assign lineSynced[gi] = stages[1];
        end
    endgenerate

    // edge history starts low, the idle level of both lines, so reset makes no false edge
    always @(posedge clk) begin
        if (!rst_n) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= selLevel;
        end
    end

    assign isExternal = (trigger_origin_select == `ORIGIN_LINE1) ||
                        (trigger_origin_select == `ORIGIN_LINE2);
    assign selLevel = (trigger_origin_select == `ORIGIN_LINE2) ? lineSynced[1] : lineSynced[0];
    // low-level activation inverts the line so pulse-width mode follows it
    assign activeLevel = (triggerActivation == `ACT_LOW) ? ~selLevel : selLevel;

    function trig_hit;
        input [1:0] act;
        input cur;
        input prev;
        begin
            case (act)
                `ACT_RISING: trig_hit = cur & ~prev;
                `ACT_ANY: trig_hit = cur ^ prev;
                `ACT_HIGH: trig_hit = cur;
                `ACT_LOW: trig_hit = ~cur;
                default: trig_hit = 1'b0;
            endcase
        end
    endfunction

    assign extTrigger = triggerEnable && isExternal && trig_hit(triggerActivation, selLevel, prevLevel);

    // microsecond tick as a one-cycle enable;
    // keeping one clock avoids any crossing between the timer and the sequencer
    always @(posedge clk) begin
        if (!rst_n) begin
            tickCount <= 8'h00;
            usTick <= 1'b0;
        end else if (tickCount == TICK_LAST[7:0]) begin
            tickCount <= 8'h00;
            usTick <= 1'b1;
        end else begin
            tickCount <= tickCount + 8'h01;
            usTick <= 1'b0;
        end
    end

    // exposure clamped to the fixed minimum
    assign effExposure = (integration_duration_setting < `MIN_EXPOSURE_US) ?
                         `MIN_EXPOSURE_US : integration_duration_setting;
    // internal period never shorter than delay plus exposure plus two us; the start, hand-over and
    // readout cycles would otherwise push every other internal trigger outside idle at a short tick
    assign minPeriod = {1'b0, effExposure} + {1'b0, post_trigger_delay} + {{(TIME_BITS-1){1'b0}}, 2'b10};
    assign effPeriod = ({1'b0, linePeriodSetting} < minPeriod) ? minPeriod : {1'b0, linePeriodSetting};

    // timer restarts whenever it is deselected, so the first internal line comes a full period later
    always @(posedge clk) begin
        if (!rst_n) begin
            periodCount <= {TIME_BITS{1'b0}};
        end else if (trigger_origin_select != `ORIGIN_INTERNAL || !triggerEnable) begin
            periodCount <= {TIME_BITS{1'b0}};
        end else if (usTick) begin
            if ({1'b0, periodCount} + {{TIME_BITS{1'b0}}, 1'b1} >= effPeriod)
                periodCount <= {TIME_BITS{1'b0}};
            else
                periodCount <= periodCount + {{(TIME_BITS-1){1'b0}}, 1'b1};
        end
    end

    assign internalTrigger = triggerEnable && (trigger_origin_select == `ORIGIN_INTERNAL) && usTick &&
                             ({1'b0, periodCount} + {{TIME_BITS{1'b0}}, 1'b1} >= effPeriod);
    // software command fires regardless of the selected origin
    assign lineTrigger = internalTrigger || extTrigger || softwareTrigger;

    // exposure sequencer
    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            timeCount <= {TIME_BITS{1'b0}};
            integrating <= 1'b0;
            line_begin_trigger <= 1'b0;
            integration_begin_event <= 1'b0;
            lineReadout <= 1'b0;
            triggerIgnored <= 1'b0;
        end else begin
            line_begin_trigger <= 1'b0;
            integration_begin_event <= 1'b0;
            lineReadout <= 1'b0;
            // a trigger while busy is dropped, not queued
            triggerIgnored <= lineTrigger && (state != ST_IDLE) &&
                              !(exposure_method_select == `METHOD_PULSE && trigger_origin_select != `ORIGIN_INTERNAL &&
                                trig_hit(`ACT_HIGH, activeLevel, 1'b0));
            case (state)
                ST_IDLE: begin
                    // only idle takes a trigger; this is what drops early and overlapping ones
                    if (lineTrigger) begin
                        line_begin_trigger <= 1'b1;
                        timeCount <= {TIME_BITS{1'b0}};
                        state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    // zero delay starts integration on the cycle after line begin
                    if (timeCount >= post_trigger_delay) begin
                        integration_begin_event <= 1'b1;
                        integrating <= 1'b1;
                        timeCount <= {TIME_BITS{1'b0}};
                        state <= ST_EXPOSE;
                    end else if (usTick) begin
                        timeCount <= timeCount + {{(TIME_BITS-1){1'b0}}, 1'b1};
                    end
                end
                ST_EXPOSE: begin
                    case (exposure_method_select)
                        `METHOD_PULSE: begin
                            // pulse width needs an external line; otherwise fall back to timed
                            if (isExternal ? !activeLevel : (timeCount >= effExposure)) begin
                                integrating <= 1'b0;
                                lineReadout <= 1'b1;
                                state <= ST_READ;
                            end else if (usTick) begin
                                timeCount <= timeCount + {{(TIME_BITS-1){1'b0}}, 1'b1};
                            end
                        end
                        default: begin
                            if (timeCount >= effExposure) begin
                                integrating <= 1'b0;
                                lineReadout <= 1'b1;
                                state <= ST_READ;
                            end else if (usTick) begin
                                timeCount <= timeCount + {{(TIME_BITS-1){1'b0}}, 1'b1};
                            end
                        end
                    endcase
                end
                ST_READ: begin
                    // readout hand-off is one cycle; the pixel path runs independently
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // conversion gain selector, out-of-range writes are ignored
    always @(posedge clk) begin
        if (!rst_n) begin
            conversionGain <= `GAIN_SEL_RESET;
        end else if (conversionGainWrite && conversion_gain_select >= `GAIN_SEL_MIN &&
                     conversion_gain_select <= `GAIN_SEL_MAX) begin
            conversionGain <= conversion_gain_select;
        end
    end

    // pixel path: multiply, offset, saturate
    wire [`PIXEL_BITS+MULT_BITS-1:0] product;
    wire [`PIXEL_BITS+MULT_BITS-`MULT_FRAC_BITS-1:0] scaled;
    wire signed [`PIXEL_BITS+MULT_BITS-`MULT_FRAC_BITS+1:0] withOffset;
    reg [`PIXEL_BITS-1:0] next_pixel;

    assign product = sensorPixel * post_sensor_multiplier;
    assign scaled = product[`PIXEL_BITS+MULT_BITS-1:`MULT_FRAC_BITS];
    assign withOffset = $signed({2'b00, scaled}) + $signed(BASELINE) + dark_offset;

    // a negative offset can pull dark pixels below zero, so clip at both ends
    always @* begin
        if (withOffset < 0)
            next_pixel = {`PIXEL_BITS{1'b0}};
        else if (withOffset > $signed({2'b00, {(MULT_BITS-`MULT_FRAC_BITS){1'b0}}, `PIXEL_MAX}))
            next_pixel = `PIXEL_MAX;
        else
            next_pixel = withOffset[`PIXEL_BITS-1:0];
    end

    // valid and last ride the same register as the data so they stay aligned
    always @(posedge clk) begin
        if (!rst_n) begin
            pixelOut <= {`PIXEL_BITS{1'b0}};
            pixelOutValid <= 1'b0;
            pixelOutLast <= 1'b0;
        end else begin
            pixelOut <= next_pixel;
            pixelOutValid <= sensorPixelValid;
            pixelOutLast <= sensorPixelValid & sensorLineLast;
        end
    end

endmodule // line_exposure_gain_control

`default_nettype wire

// ### tb/exposure_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "line_exposure_regs.vh"
module exposure_monitor #(
    parameter TIME_BITS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and stimulus
    input wire logic exposure_method_select,
    input wire logic [1:0] trigger_origin_select,
    input wire logic [1:0] triggerActivation,
    input wire logic [TIME_BITS-1:0] post_trigger_delay,
    input wire logic softwareTrigger,
    input wire logic triggerLine2,
    input wire logic [2:0] conversion_gain_select,
    input wire logic conversionGainWrite,
    input wire logic sensorPixelValid,
    input wire logic sensorLineLast,
    // observed outputs
    input wire logic integrating,
    input wire logic line_begin_trigger,
    input wire logic integration_begin_event,
    input wire logic lineReadout,
    input wire logic [2:0] conversionGain,
    input wire logic triggerIgnored,
    input wire logic pixelOutValid,
    input wire logic pixelOutLast
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire gainOk = conversionGainWrite && conversion_gain_select >= `GAIN_SEL_MIN
        && conversion_gain_select <= `GAIN_SEL_MAX;
    wire pulseCfg = exposure_method_select == `METHOD_PULSE && trigger_origin_select == `ORIGIN_LINE2
        && triggerActivation == `ACT_HIGH;
    // synchroniser plus register needs a few low cycles before the level is seen
    sequence lineLow4;
        (!triggerLine2) [*4];
    endsequence
    begin_idle_a: assert property (line_begin_trigger |-> !integrating ##1 !line_begin_trigger)
        else $error("line begin outside idle or too long");
    zero_delay_a: assert property (line_begin_trigger && post_trigger_delay == '0 |=> integration_begin_event)
        else $error("integration start late with zero delay");
    begin_int_a: assert property (integration_begin_event |-> integrating)
        else $error("start event without integration");
    readout_end_a: assert property (lineReadout |-> !integrating && $past(integrating))
        else $error("readout not at end of integration");
    drop_flag_a: assert property (softwareTrigger && integrating |-> ##[1:2] triggerIgnored)
        else $error("busy trigger not flagged");
    pulse_end_a: assert property (pulseCfg throughout lineLow4 |-> !integrating)
        else $error("integration outlives trigger level");
    gain_load_a: assert property (gainOk |=> conversionGain == $past(conversion_gain_select))
        else $error("gain setting not loaded");
    gain_hold_a: assert property (!gainOk |=> $stable(conversionGain))
        else $error("gain changed without valid write");
    gain_reset_a: assert property (disable iff (1'b0) $rose(rst_n) |-> conversionGain == `GAIN_SEL_RESET)
        else $error("gain reset value wrong");
    pix_follow_a: assert property (sensorPixelValid |=> pixelOutValid && pixelOutLast == $past(sensorLineLast))
        else $error("pixel stream not passed on");
endmodule // exposure_monitor
bind line_exposure_gain_control exposure_monitor #(.TIME_BITS(TIME_BITS)) monitor (.clk(clk), .rst_n(rst_n),
    .exposure_method_select(exposure_method_select), .trigger_origin_select(trigger_origin_select),
    .triggerActivation(triggerActivation), .post_trigger_delay(post_trigger_delay),
    .softwareTrigger(softwareTrigger), .triggerLine2(triggerLine2), .conversion_gain_select(conversion_gain_select),
    .conversionGainWrite(conversionGainWrite), .sensorPixelValid(sensorPixelValid),
    .sensorLineLast(sensorLineLast), .integrating(integrating), .line_begin_trigger(line_begin_trigger),
    .integration_begin_event(integration_begin_event), .lineReadout(lineReadout),
    .conversionGain(conversionGain), .triggerIgnored(triggerIgnored), .pixelOutValid(pixelOutValid),
    .pixelOutLast(pixelOutLast));
`default_nettype wire

// ### tb/trigger_source.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_source (
    // clock
    input wire logic clk,
    // trigger pins
    output logic triggerLine1,
    output logic triggerLine2
);
    initial begin
        triggerLine1 = 1'b0;
        triggerLine2 = 1'b0;
    end
    // equal low gap after each pulse keeps the rate legal and the delay under half a period
    task automatic pulse(input int line, input int width);
        @(negedge clk);
        if (line == 1) triggerLine1 = 1'b1; else triggerLine2 = 1'b1;
        repeat (width) @(negedge clk);
        triggerLine1 = 1'b0;
        triggerLine2 = 1'b0;
        repeat (width) @(negedge clk);
    endtask
endmodule // trigger_source
`default_nettype wire

// ### tb/line_exposure_gain_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module line_exposure_gain_control_tb;
    logic clk = 0, rst_n = 0, meth = 0, swTrig = 0, en = 0, gWr = 0, pv = 0, pl = 0, f;
    logic [1:0] org = 2'h3, act = 2'h0;
    logic [15:0] expo = 16'h0005, dly = 16'h0003, per = 16'h0028;
    logic [2:0] gSel = 3'h0, e = 3'h4;
    logic [11:0] mult = 12'h100, pix = 12'h000;
    logic signed [9:0] off = 10'h000;
    wire line1, line2, integ, lbt, ibe, rdo, ign, pvo, plo;
    wire [2:0] cg;
    wire [11:0] po;
    int miscompares = 0, comparisons = 0, d, w, i, g;
    int tp[4] = '{256, 4095, 16, 2048}, tm[4] = '{256, 512, 256, 128}, to[4] = '{0, 100, -200, -5};
    always #10 clk = ~clk;
    trigger_source src (.clk(clk), .triggerLine1(line1), .triggerLine2(line2));
    line_exposure_gain_control #(.TICK_CYCLES(2), .BASELINE(12'h040)) dut (.clk(clk), .rst_n(rst_n),
        .exposure_method_select(meth), .trigger_origin_select(org), .triggerActivation(act), .triggerEnable(en),
        .integration_duration_setting(expo), .post_trigger_delay(dly), .linePeriodSetting(per),
        .softwareTrigger(swTrig), .triggerLine1(line1), .triggerLine2(line2), .conversion_gain_select(gSel),
        .conversionGainWrite(gWr), .post_sensor_multiplier(mult), .dark_offset(off), .sensorPixel(pix),
        .sensorPixelValid(pv), .sensorLineLast(pl), .integrating(integ), .line_begin_trigger(lbt),
        .integration_begin_event(ibe), .lineReadout(rdo), .conversionGain(cg), .triggerIgnored(ign),
        .pixelOut(po), .pixelOutValid(pvo), .pixelOutLast(plo));
    task final_report;
        $display("Counts: %0d mismatches in %0d comparisons", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // tick alignment makes measured spans wobble by a cycle or two
    task near(input int got, input int exp);
        check({15'h0, got >= exp - 3 && got <= exp + 3}, 16'h0001);
    endtask
    task waitLbt(output int n);
        n = 0;
        do begin @(negedge clk); n++; end while (lbt !== 1'b1 && n < 2000);
        if (n >= 2000) begin miscompares++; final_report(); end
    endtask
    task measure(output int dd, output int ww);
        int n;
        waitLbt(n);
        dd = 0;
        ww = 0;
        while (ibe !== 1'b1 && dd < 2000) begin @(negedge clk); dd++; end
        while (rdo !== 1'b1 && ww < 2000) begin @(negedge clk); ww++; end
        if (ww >= 2000) begin miscompares++; final_report(); end
        repeat (3) @(negedge clk);
    endtask
    task fire;
        swTrig = 1'b1;
        @(negedge clk);
        swTrig = 1'b0;
    endtask
    function int expPix(int p, int m, int o);
        int v;
        v = ((p * m) >>> 8) + 64 + o;
        return v < 0 ? 0 : (v > 4095 ? 4095 : v);
    endfunction
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(cg, 3'h4);
        for (i = 0; i < 8; i++) begin
            gSel = i[2:0];
            gWr = 1'b1;
            if (i >= 1 && i <= 4) e = i[2:0];
            @(negedge clk);
            gWr = 1'b0;
            check(cg, e);
        end
        for (i = 0; i < 4; i++) begin
            pix = tp[i][11:0];
            mult = tm[i][11:0];
            off = to[i][9:0];
            pv = 1'b1;
            pl = (i == 3);
            @(negedge clk);
            check({pvo, plo, po}, {pv, pl, 12'(expPix(tp[i], tm[i], to[i]))});
        end
        pv = 1'b0;
        fork
            fire();
            measure(d, w);
            begin repeat (12) @(negedge clk); fire(); f = ign; @(negedge clk); check(f | ign, 1); end
        join
        near(d, 7);
        near(w, 10);
        dly = 16'h0000;
        expo = 16'h0001;
        fork fire(); measure(d, w); join
        near(w, 8);
        org = 2'h1;
        en = 1'b1;
        for (i = 0; i < 2; i++) begin
            act = i[1:0];
            fork src.pulse(1, 5); measure(d, w); join
            near(w, 8);
        end
        meth = 1'b1;
        org = 2'h2;
        act = 2'h2;
        fork src.pulse(2, 30); measure(d, w); join
        near(w, 29);
        meth = 1'b0;
        act = 2'h0;
        org = 2'h0;
        expo = 16'h0004;
        waitLbt(d);
        waitLbt(g);
        near(g, 80);
        per = 16'h0002;
        waitLbt(d);
        waitLbt(g);
        near(g, 12);
        en = 1'b0;
        org = 2'h3;
        final_report();
    end
endmodule // line_exposure_gain_control_tb
`default_nettype wire
